// ==== shared/bru_pkg.sv ====
// byte rotate unit package: operation codes and widths
// assumes a single-clock core datapath around the unit
package bru_pkg;
	localparam int unsigned BRU_DATA_W = 8;               // data byte width
	localparam int unsigned BRU_MSB    = 7;               // top bit index
	localparam logic [7:0]  BRU_BYTE_RST = 8'h00;         // reset value of byte registers
	localparam logic        BRU_FLAG_RST = 1'b0;          // reset value of carry

	// operation select, encoded on the op port
	typedef enum logic [2:0] {
		BRU_OP_ROTATE_LEFT_THRU_FLAG,
		BRU_OP_ROTATE_LEFT_THRU_FLAG_TO_WORKING,
		BRU_OP_ROTATE_RIGHT_INPLACE,
		BRU_OP_ROTATE_RIGHT_TO_WORKING,
		BRU_OP_ROTATE_RIGHT_THRU_FLAG,
		BRU_OP_ROTATE_RIGHT_THRU_FLAG_TO_WORKING
	} bru_op_type;
endpackage : bru_pkg

// ==== src/bru_rotator.sv ====
// byte rotate unit: combinational one-bit rotator leaf
// assumes caller supplies direction, fill bit and operand in one cycle
module bru_rotator
	import bru_pkg::*;
(
	input  wire logic [BRU_DATA_W-1:0] data_i,    // operand byte
	input  wire logic                  left_i,    // 1 rotate left, 0 right
	input  wire logic                  fill_i,    // bit entering the vacated end
	output logic      [BRU_DATA_W-1:0] result_o,  // rotated byte
	output logic                       out_bit_o  // bit leaving the byte
);
	// shift one place, fill the vacated end, report the bit pushed out
	always_comb begin
		if (left_i) begin
			result_o  = {data_i[BRU_MSB-1:0], fill_i};
			out_bit_o = data_i[BRU_MSB];
		end else begin
			result_o  = {fill_i, data_i[BRU_MSB:1]};
			out_bit_o = data_i[0];
		end
	end
endmodule : bru_rotator

// ==== src/bru_top.sv ====
// byte rotate unit top: executes six rotate operations on a memory byte
// assumes decode presents op, byte and start; memory write is done from wr pulse
// Operation
// - left thru carry: bit0 gets old carry, carry gets bit7, write back byte
// - same left rotate thru carry into working register; memory untouched
// - right rotate, bit0 into bit7, write back, flags untouched
// - right rotate into working register; memory and carry unchanged
// - right thru carry: bit7 gets old carry, carry gets bit0, write back
// - same right rotate thru carry into working register; memory untouched
module bru_top
	import bru_pkg::*;
(
	input  wire logic                  SYS_CLK_I,     // core clock, 40 MHz
	input  wire logic                  RSTN_I,        // async reset, active low
	input  wire logic                  START_I,       // one-cycle execute strobe
	input  wire bru_op_type            OP_I,          // operation select
	input  wire logic [BRU_DATA_W-1:0] MEM_DATA_I,    // addressed byte read value
	input  wire logic                  CARRY_LD_I,    // load carry from core
	input  wire logic                  CARRY_VAL_I,   // carry value to load
	output logic [BRU_DATA_W-1:0]      MEM_WDATA_O,   // byte to write back
	output logic                       MEM_WR_O,      // write-back pulse
	output logic [BRU_DATA_W-1:0]      WORKING_O,     // working register
	output logic                       CARRY_O,       // carry flag
	output logic                       DONE_O         // result ready pulse
);
	// full unit state
	typedef struct packed {
		logic [BRU_DATA_W-1:0] wdata;
		logic                  wr;
		logic [BRU_DATA_W-1:0] working;
		logic                  carry;
		logic                  done;
	} bru_state_type;

	bru_state_type st_r;
	bru_state_type st_nxt;

	logic                  rot_left;
	logic                  rot_thru;
	logic                  rot_fill;
	logic [BRU_DATA_W-1:0] rot_res;
	logic                  rot_out;

	// direction and carry use per operation
	always_comb begin
		rot_left = 1'b0;
		rot_thru = 1'b0;
		unique case (OP_I)
			BRU_OP_ROTATE_LEFT_THRU_FLAG: begin
				rot_left = 1'b1;
				rot_thru = 1'b1;
			end
			BRU_OP_ROTATE_LEFT_THRU_FLAG_TO_WORKING: begin
				rot_left = 1'b1;
				rot_thru = 1'b1;
			end
			BRU_OP_ROTATE_RIGHT_INPLACE:             rot_thru = 1'b0;
			BRU_OP_ROTATE_RIGHT_TO_WORKING:          rot_thru = 1'b0;
			BRU_OP_ROTATE_RIGHT_THRU_FLAG:           rot_thru = 1'b1;
			BRU_OP_ROTATE_RIGHT_THRU_FLAG_TO_WORKING: rot_thru = 1'b1;
			default: begin
				rot_left = 1'b0;
				rot_thru = 1'b0;
			end
		endcase
	end

	// plain rotates feed the wrapped end bit, carry forms feed old carry
	assign rot_fill = rot_thru ? st_r.carry : (rot_left ? MEM_DATA_I[BRU_MSB] : MEM_DATA_I[0]);

	bru_rotator u_rot (
		.data_i    (MEM_DATA_I),
		.left_i    (rot_left),
		.fill_i    (rot_fill),
		.result_o  (rot_res),
		.out_bit_o (rot_out)
	);

	function automatic logic to_working(input bru_op_type op);
		return op == BRU_OP_ROTATE_LEFT_THRU_FLAG_TO_WORKING ||
		       op == BRU_OP_ROTATE_RIGHT_TO_WORKING ||
		       op == BRU_OP_ROTATE_RIGHT_THRU_FLAG_TO_WORKING;
	endfunction : to_working

	// next state; a thru-carry rotate wins over external carry load in the same cycle, a plain rotate lets it land
	always_comb begin
		st_nxt      = st_r;
		st_nxt.wr   = 1'b0;
		st_nxt.done = 1'b0;
		if (CARRY_LD_I) begin
			st_nxt.carry = CARRY_VAL_I;
		end
		if (START_I) begin
			st_nxt.done = 1'b1;
			if (to_working(OP_I)) begin
				st_nxt.working = rot_res;
			end else begin
				st_nxt.wdata = rot_res;
				st_nxt.wr    = 1'b1;
			end
			if (rot_thru) begin
				st_nxt.carry = rot_out;
			end
		end
	end

	// single state register
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st_r <= '{wdata: BRU_BYTE_RST, wr: 1'b0, working: BRU_BYTE_RST,
			          carry: BRU_FLAG_RST, done: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign MEM_WDATA_O = st_r.wdata;
	assign MEM_WR_O    = st_r.wr;
	assign WORKING_O   = st_r.working;
	assign CARRY_O     = st_r.carry;
	assign DONE_O      = st_r.done;

	// result checks, one cycle after the taking edge
	property p_left_thru_mem;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && OP_I == BRU_OP_ROTATE_LEFT_THRU_FLAG |=>
			MEM_WR_O && MEM_WDATA_O == {$past(MEM_DATA_I[6:0]), $past(CARRY_O)}
			&& CARRY_O == $past(MEM_DATA_I[7]);
	endproperty
	a_left_thru_mem: assert property (p_left_thru_mem) else $error("left thru carry wrong");

	property p_left_thru_work;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && OP_I == BRU_OP_ROTATE_LEFT_THRU_FLAG_TO_WORKING |=>
			!MEM_WR_O && WORKING_O == {$past(MEM_DATA_I[6:0]), $past(CARRY_O)}
			&& CARRY_O == $past(MEM_DATA_I[7]);
	endproperty
	a_left_thru_work: assert property (p_left_thru_work) else $error("left to working wrong");

	property p_right_mem;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && !CARRY_LD_I && OP_I == BRU_OP_ROTATE_RIGHT_INPLACE |=>
			MEM_WR_O && MEM_WDATA_O == {$past(MEM_DATA_I[0]), $past(MEM_DATA_I[7:1])}
			&& $stable(CARRY_O);
	endproperty
	a_right_mem: assert property (p_right_mem) else $error("right rotate wrong");

	property p_right_work;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && !CARRY_LD_I && OP_I == BRU_OP_ROTATE_RIGHT_TO_WORKING |=>
			!MEM_WR_O && WORKING_O == {$past(MEM_DATA_I[0]), $past(MEM_DATA_I[7:1])}
			&& $stable(CARRY_O);
	endproperty
	a_right_work: assert property (p_right_work) else $error("right to working wrong");

	property p_right_thru_mem;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && OP_I == BRU_OP_ROTATE_RIGHT_THRU_FLAG |=>
			MEM_WR_O && MEM_WDATA_O == {$past(CARRY_O), $past(MEM_DATA_I[7:1])}
			&& CARRY_O == $past(MEM_DATA_I[0]);
	endproperty
	a_right_thru_mem: assert property (p_right_thru_mem) else $error("right thru wrong");

	property p_right_thru_work;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && OP_I == BRU_OP_ROTATE_RIGHT_THRU_FLAG_TO_WORKING |=>
			!MEM_WR_O && WORKING_O == {$past(CARRY_O), $past(MEM_DATA_I[7:1])}
			&& CARRY_O == $past(MEM_DATA_I[0]);
	endproperty
	a_right_thru_work: assert property (p_right_thru_work) else $error("right thru working bad");

	// a to-working op must not raise the write strobe nor move the write-back byte
	property p_work_keeps_mem;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && to_working(OP_I) |=>
			!MEM_WR_O && $stable(MEM_WDATA_O);
	endproperty
	a_work_keeps_mem: assert property (p_work_keeps_mem)
		else $error("working op touched memory");

	// an in-place op leaves the working register as it was
	property p_mem_keeps_work;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && !to_working(OP_I) |=>
			$stable(WORKING_O);
	endproperty
	a_mem_keeps_work: assert property (p_mem_keeps_work)
		else $error("in-place op touched working register");

	// done follows every taken strobe by exactly one cycle
	property p_done_pulse;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I |=> DONE_O;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done missing after strobe");

	// strobes drop after one cycle; a stuck write would corrupt memory
	property p_idle_quiet;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		!START_I |=> !DONE_O && !MEM_WR_O;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("strobe held without a request");

	// carry only moves on a rotate or a core load
	property p_carry_quiet;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		!START_I && !CARRY_LD_I |=> $stable(CARRY_O);
	endproperty
	a_carry_quiet: assert property (p_carry_quiet)
		else $error("carry moved while idle");

	// plain rotates leave carry to the core, so a same-cycle load still lands
	property p_plain_load;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && CARRY_LD_I && (OP_I == BRU_OP_ROTATE_RIGHT_INPLACE ||
			OP_I == BRU_OP_ROTATE_RIGHT_TO_WORKING) |=>
			CARRY_O == $past(CARRY_VAL_I);
	endproperty
	a_plain_load: assert property (p_plain_load)
		else $error("carry load lost on plain rotate");

	// spare codes act as a plain right rotate with write-back, never a hang
	property p_spare_code;
		@(posedge SYS_CLK_I) disable iff (!RSTN_I)
		START_I && !CARRY_LD_I && 3'(OP_I) > 3'h5 |=>
			MEM_WR_O && MEM_WDATA_O == {$past(MEM_DATA_I[0]), $past(MEM_DATA_I[7:1])}
			&& $stable(CARRY_O);
	endproperty
	a_spare_code: assert property (p_spare_code)
		else $error("spare code misbehaved");
endmodule : bru_top

// ==== bench/byte_rotate_unit_tb_top.sv ====
// bench for the byte rotate unit: one task per rotate group, plus carry clash, spare code and reset tasks
// assumes bru_top and bru_pkg; this module drives every input itself
module byte_rotate_unit_tb_top
	import bru_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk     = 1'b0;
	logic       rstn_n  = 1'b0;
	logic       start   = 1'b0;
	bru_op_type op      = BRU_OP_ROTATE_LEFT_THRU_FLAG;
	logic [7:0] mem     = 8'h00;
	logic       cld     = 1'b0;
	logic       cval    = 1'b0;
	logic [7:0] wdata;
	logic       wr;
	logic [7:0] work;
	logic       carry;
	logic       done;
	int         mismatches      = 0;
	int         samples_checked = 0;
	int         cycles          = 0;

	// 40 MHz core clock
	always #12.5 clk = ~clk;

	bru_top i_dut (
		.SYS_CLK_I(clk), .RSTN_I(rstn_n), .START_I(start), .OP_I(op), .MEM_DATA_I(mem),
		.CARRY_LD_I(cld), .CARRY_VAL_I(cval), .MEM_WDATA_O(wdata), .MEM_WR_O(wr),
		.WORKING_O(work), .CARRY_O(carry), .DONE_O(done)
	);

	// one compare for all results, widened to a byte and made with !== so unknowns never match
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic set_carry(input logic v);
		@(posedge clk);
		cld <= 1'b1;
		cval <= v;
		@(posedge clk);
		cld <= 1'b0;
		#1;
		chk("carry load", {7'h00, v}, {7'h00, carry});
		chk("idle strobes", 8'h00, {6'h00, wr, done});
	endtask : set_carry

	// every output at its cleared value
	task automatic chk_cleared;
		chk("cleared write data", 8'h00, wdata);
		chk("cleared working", 8'h00, work);
		chk("cleared flags", 8'h00, {5'h00, wr, done, carry});
	endtask : chk_cleared

	// one strobe, with an optional carry load in the same cycle; outputs settled on return
	task automatic pulse(input bru_op_type o, input logic [7:0] d, input logic ld,
		input logic lv);
		@(posedge clk);
		start <= 1'b1;
		op    <= o;
		mem   <= d;
		cld   <= ld;
		cval  <= lv;
		@(posedge clk);
		start <= 1'b0;
		cld   <= 1'b0;
		#1;
	endtask : pulse

	// one operation, judged one cycle later; the untouched destination must hold
	task automatic run_op(input bru_op_type o, input logic [7:0] d, input logic [7:0] e,
		input logic ec);
		logic       wb;
		logic [7:0] old_w;
		logic [7:0] old_m;
		wb = o inside {BRU_OP_ROTATE_LEFT_THRU_FLAG, BRU_OP_ROTATE_RIGHT_INPLACE,
			BRU_OP_ROTATE_RIGHT_THRU_FLAG};
		old_w = work;
		old_m = wdata;
		pulse(o, d, 1'b0, 1'b0);
		chk("done", 8'h01, {7'h00, done});
		chk("write strobe", {7'h00, wb}, {7'h00, wr});
		chk("write data", wb ? e : old_m, wdata);
		chk("working", wb ? old_w : e, work);
		chk("carry", {7'h00, ec}, {7'h00, carry});
	endtask : run_op

	// carry chains: the second op sees the carry left by the first
	task automatic s_left_thru;
		set_carry(1'b1);
		run_op(BRU_OP_ROTATE_LEFT_THRU_FLAG, 8'h80, 8'h01, 1'b1);
		run_op(BRU_OP_ROTATE_LEFT_THRU_FLAG, 8'h40, 8'h81, 1'b0);
	endtask : s_left_thru

	task automatic s_left_work;
		set_carry(1'b0);
		run_op(BRU_OP_ROTATE_LEFT_THRU_FLAG_TO_WORKING, 8'hfe, 8'hfc, 1'b1);
	endtask : s_left_work

	// plain rotates must leave either carry value alone
	task automatic s_right_plain;
		set_carry(1'b1);
		run_op(BRU_OP_ROTATE_RIGHT_INPLACE, 8'h02, 8'h01, 1'b1);
		set_carry(1'b0);
		run_op(BRU_OP_ROTATE_RIGHT_INPLACE, 8'h01, 8'h80, 1'b0);
		run_op(BRU_OP_ROTATE_RIGHT_TO_WORKING, 8'h03, 8'h81, 1'b0);
	endtask : s_right_plain

	task automatic s_right_thru;
		set_carry(1'b1);
		run_op(BRU_OP_ROTATE_RIGHT_THRU_FLAG, 8'h01, 8'h80, 1'b1);
		run_op(BRU_OP_ROTATE_RIGHT_THRU_FLAG, 8'h02, 8'h81, 1'b0);
		run_op(BRU_OP_ROTATE_RIGHT_THRU_FLAG_TO_WORKING, 8'h01, 8'h00, 1'b1);
	endtask : s_right_thru

	// a thru-carry rotate beats a same-cycle carry load; a plain rotate lets it land
	task automatic s_carry_clash;
		set_carry(1'b0);
		pulse(BRU_OP_ROTATE_RIGHT_THRU_FLAG, 8'h01, 1'b1, 1'b0);
		chk("clash write data", 8'h00, wdata);
		chk("clash carry", 8'h01, {7'h00, carry});
		pulse(BRU_OP_ROTATE_RIGHT_TO_WORKING, 8'h10, 1'b1, 1'b0);
		chk("plain working", 8'h08, work);
		chk("plain carry load", 8'h00, {7'h00, carry});
	endtask : s_carry_clash

	// spare codes behave as a plain right rotate with write-back
	task automatic s_spare_codes;
		set_carry(1'b1);
		pulse(bru_op_type'(3'h6), 8'h01, 1'b0, 1'b0);
		chk("spare write data", 8'h80, wdata);
		chk("spare flags", 8'h07, {5'h00, wr, done, carry});
		pulse(bru_op_type'(3'h7), 8'h02, 1'b0, 1'b0);
		chk("spare write data", 8'h01, wdata);
		chk("spare flags", 8'h07, {5'h00, wr, done, carry});
	endtask : s_spare_codes

	// mid-run reset clears all at once; the first op after it sees carry 0
	task automatic s_reset_mid;
		@(posedge clk);
		rstn_n <= 1'b0;
		#1;
		chk_cleared();
		repeat (2) @(posedge clk);
		rstn_n <= 1'b1;
		run_op(BRU_OP_ROTATE_LEFT_THRU_FLAG, 8'h81, 8'h02, 1'b1);
	endtask : s_reset_mid

	task automatic give_verdict;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// hang guard, far above the few dozen cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rstn_n <= 1'b1;
		#1;
		chk_cleared();
		s_left_thru();
		s_left_work();
		s_right_plain();
		s_right_thru();
		s_carry_clash();
		s_spare_codes();
		s_reset_mid();
		give_verdict();
	end
endmodule : byte_rotate_unit_tb_top
